// ### core/smi_device.sv
// management serial slave with indirect extended-space access
//
// Behaviour
// - station keeps MDC at or below 24 MHz
// - works with MDC stopped while idle
// - bits captured on MDC rising edge
// - strapped 4-bit address, answer only it
// - station idles two MDC cycles after reset
// - register field selects one of 32 words
// - frame recognised only on start 01
// - read: release TA1, drive 0, data
// - write: station drives TA 10 and data
// - indexes 0x0 to 0x1F reached directly, except 0xE
// - control at 0xD, address/data at 0xE
// - spaces 11111, 00001, 00011 supported
// - other space selectors ignore indirect access
// - function bits 15:14 pick access mode
// - function 00 writes load the pointer
// - function 00 reads return the pointer
// - software loads pointer before data access
// - function 01 leaves pointer unchanged
// - function 10 increments after read/write
// - function 11 increments after writes only
// - software writes 0x1F or 0x1 first
`timescale 1ns/1ps
module smi_device
  import smi_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [3:0]  bus_address_straps,
  smi_if.dev               link,
  output logic             ext_rd,
  output logic             ext_wr,
  output logic [4:0]       ext_space,
  output logic [15:0]      ext_addr,
  output logic [15:0]      ext_wdata,
  input  wire logic [15:0] ext_rdata,
  output logic [3:0]       bus_addr
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0]        mdc_sync_q;
  logic [1:0]        mdio_sync_q;
  logic [3:0]        strap_s1_q;
  logic [3:0]        strap_s2_q;
  logic              mdc_rise;
  logic              mdc_fall;
  logic              bit_in;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mdc_sync_q  <= 3'h0;
      mdio_sync_q <= 2'h3;
      strap_s1_q  <= 4'h0;
      strap_s2_q  <= 4'h0;
    end
    else
    begin
      mdc_sync_q  <= {mdc_sync_q[1:0], link.mdc};
      mdio_sync_q <= {mdio_sync_q[0], link.mdio};
      strap_s1_q  <= bus_address_straps;
      strap_s2_q  <= strap_s1_q;
    end
  end

  // edges come from our own clock, so a stopped MDC simply yields none
  assign mdc_rise = mdc_sync_q[1] & ~mdc_sync_q[2];
  assign mdc_fall = ~mdc_sync_q[1] & mdc_sync_q[2];
  assign bit_in   = mdio_sync_q[1];

  // ****************************************************************
  // address strap capture
  // ****************************************************************
  logic [1:0]        strap_cnt_q;
  logic [3:0]        bus_addr_q;
  logic              addr_ok_q;

  // straps are caught once, after the synchroniser has settled past reset
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      strap_cnt_q <= 2'h0;
      bus_addr_q  <= 4'h0;
      addr_ok_q   <= 1'b0;
    end
    else if (!addr_ok_q)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == STRAP_WAIT)
      begin
        bus_addr_q <= strap_s2_q;
        addr_ok_q  <= 1'b1;
      end
    end
  end

  assign bus_addr = bus_addr_q;

  // ****************************************************************
  // frame sequencing
  // ****************************************************************
  smi_dev_state_type state_q;
  logic [4:0]        cnt_q;
  logic              last_bit_q;
  logic [15:0]       sh_q;
  logic [11:0]       hdr_w;
  logic [15:0]       data_w;
  logic              hdr_done;
  logic              frame_done;

  assign hdr_w      = {sh_q[10:0], bit_in};
  assign data_w     = {sh_q[14:0], bit_in};
  assign hdr_done   = mdc_rise && (state_q == DST_FRAME) && (cnt_q == HDR_LAST_BIT);
  assign frame_done = mdc_rise && (state_q == DST_FRAME) && (cnt_q == FRAME_LAST);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q    <= DST_IDLE;
      cnt_q      <= 5'h0;
      last_bit_q <= 1'b1;
      sh_q       <= 16'h0;
    end
    else if (mdc_rise)
    begin
      last_bit_q <= bit_in;
      case (state_q)
        DST_IDLE:
        begin
          // a zero following the high line, then a one
          if (!last_bit_q && bit_in)
          begin
            state_q <= DST_FRAME;
            cnt_q   <= 5'h0;
          end
        end
        DST_FRAME:
        begin
          sh_q  <= data_w;
          cnt_q <= cnt_q + 5'h1;
          if (cnt_q == FRAME_LAST)
          begin
            state_q    <= DST_IDLE;
            last_bit_q <= 1'b1;
          end
        end
        default:
        begin
          state_q <= DST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // header decode
  // ****************************************************************
  logic [15:0]       regs_q [0:31];
  logic [15:0]       ptr_q;
  logic [4:0]        reg_q;
  logic              rd_hit_q;
  logic              wr_hit_q;
  logic              ext_hit_q;
  smi_fn_type        fn_q;
  smi_fn_type        fn_now;
  logic              space_now;
  logic              hit_now;

  assign fn_now    = smi_fn_type'(regs_q[REG_CTRL][FN_HI:FN_LO]);
  assign space_now = smi_space_ok(regs_q[REG_CTRL][SEL_HI:0]);
  assign hit_now   = addr_ok_q && (hdr_w[9:5] == {1'b0, bus_addr_q});

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_q     <= 5'h0;
      rd_hit_q  <= 1'b0;
      wr_hit_q  <= 1'b0;
      ext_hit_q <= 1'b0;
      fn_q      <= FN_ADDR;
    end
    else if (hdr_done)
    begin
      reg_q     <= hdr_w[4:0];
      rd_hit_q  <= hit_now && (hdr_w[11:10] == OP_READ);
      wr_hit_q  <= hit_now && (hdr_w[11:10] == OP_WRITE);
      ext_hit_q <= (hdr_w[4:0] == REG_DATA) && space_now;
      fn_q      <= fn_now;
    end
    else if (frame_done)
    begin
      rd_hit_q <= 1'b0;
      wr_hit_q <= 1'b0;
    end
  end

  // ****************************************************************
  // register file, pointer and extended-space strobes
  // ****************************************************************
  logic              ptr_step;

  // function 10 steps on either direction, 11 on writes only, 00/01 never
  assign ptr_step = ext_hit_q && ((fn_q == FN_INC_RW && (rd_hit_q || wr_hit_q))
                    || (fn_q == FN_INC_WR && wr_hit_q));

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 32; i++)
      begin
        regs_q[i] <= REG_RST;
      end
      ptr_q     <= PTR_RST;
      ext_wr    <= 1'b0;
      ext_wdata <= 16'h0;
      ext_addr  <= PTR_RST;
    end
    else
    begin
      ext_wr <= 1'b0;
      // trails the pointer a cycle so a stepped write still lands on its own word
      ext_addr <= ptr_q;
      if (frame_done)
      begin
        if (wr_hit_q && reg_q != REG_DATA)
        begin
          regs_q[reg_q] <= data_w;
        end
        if (wr_hit_q && ext_hit_q && fn_q == FN_ADDR)
        begin
          ptr_q <= data_w;
        end
        else if (ptr_step)
        begin
          ptr_q <= ptr_q + 16'h1;
        end
        if (wr_hit_q && ext_hit_q && fn_q != FN_ADDR)
        begin
          ext_wr    <= 1'b1;
          ext_wdata <= data_w;
        end
      end
    end
  end

  assign ext_space = regs_q[REG_CTRL][SEL_HI:0];

  // ****************************************************************
  // read data and pin drive
  // ****************************************************************
  logic [15:0]       rdata_q;
  logic              rd_cap_q;
  logic              mdo_q;
  logic              mdoe_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_q  <= 16'h0;
      rd_cap_q <= 1'b0;
      ext_rd   <= 1'b0;
      mdo_q    <= 1'b1;
      mdoe_q   <= 1'b0;
    end
    else
    begin
      ext_rd   <= hdr_done && hit_now && (hdr_w[11:10] == OP_READ)
                  && (hdr_w[4:0] == REG_DATA) && space_now && fn_now != FN_ADDR;
      rd_cap_q <= ext_rd;
      if (hdr_done)
      begin
        if (hdr_w[4:0] != REG_DATA)
        begin
          rdata_q <= regs_q[hdr_w[4:0]];
        end
        else if (space_now && fn_now == FN_ADDR)
        begin
          rdata_q <= ptr_q;
        end
        else
        begin
          rdata_q <= 16'h0;
        end
      end
      else if (rd_cap_q)
      begin
        rdata_q <= ext_rdata;
      end
      else if (mdc_fall && rd_hit_q && cnt_q >= DATA_FIRST)
      begin
        mdo_q   <= rdata_q[15];
        rdata_q <= {rdata_q[14:0], 1'b0};
      end
      else if (mdc_fall && rd_hit_q && cnt_q == TA2_BIT)
      begin
        mdo_q  <= 1'b0;
        mdoe_q <= 1'b1;
      end
      // released on the last rising edge so a stopped MDC cannot leave us driving
      if (frame_done || state_q == DST_IDLE)
      begin
        mdoe_q <= 1'b0;
        mdo_q  <= 1'b1;
      end
    end
  end

  assign link.dev_mdio_o  = mdo_q;
  assign link.dev_mdio_oe = mdoe_q;

endmodule // smi_device

// ### core/smi_station.sv
// management station: makes MDC and runs one frame per command
`timescale 1ns/1ps
module smi_station
  import smi_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  smi_if.sta               link
);

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  logic [1:0]        mdio_sync_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mdio_sync_q <= 2'h3;
    end
    else
    begin
      mdio_sync_q <= {mdio_sync_q[0], link.mdio};
    end
  end

  // ****************************************************************
  // command registers
  // ****************************************************************
  smi_sta_state_type state_q;
  logic [15:0]       wdata_q;
  logic [15:0]       rx_q;
  logic              done_q;
  logic [5:0]        por_q;
  logic              start;
  logic              finish;

  // held off after reset so the bus stays quiet for over one MDC cycle
  assign start = reg_wr && reg_addr == STA_CMD && state_q == SST_IDLE && por_q == POR_IDLE;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wdata_q   <= 16'h0;
      done_q    <= 1'b0;
      por_q     <= 6'h0;
      reg_rdata <= 16'h0;
    end
    else
    begin
      if (por_q != POR_IDLE)
      begin
        por_q <= por_q + 6'h1;
      end
      if (reg_wr && reg_addr == STA_WDATA)
      begin
        wdata_q <= reg_wdata;
      end
      // a finishing frame wins over a clear in the same cycle
      if (finish)
      begin
        done_q <= 1'b1;
      end
      else if (reg_wr && reg_addr == STA_STATUS && reg_wdata[1])
      begin
        done_q <= 1'b0;
      end
      reg_rdata <= 16'h0;
      if (reg_rd)
      begin
        case (reg_addr)
          STA_WDATA:  reg_rdata <= wdata_q;
          STA_RDATA:  reg_rdata <= rx_q;
          STA_STATUS: reg_rdata <= {14'h0, done_q, state_q != SST_IDLE};
          default:    reg_rdata <= 16'h0;
        endcase
      end
    end
  end

  // ****************************************************************
  // frame engine
  // ****************************************************************
  logic [3:0]        div_q;
  logic [5:0]        bit_q;
  logic [32:0]       tx_q;
  logic [32:0]       en_q;
  logic              is_rd_q;
  logic              mdc_q;
  logic              mdo_q;
  logic              mdoe_q;
  logic              tick;

  assign tick   = div_q == MDC_HALF_M1;
  assign finish = state_q == SST_TAIL && tick;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= SST_IDLE;
      div_q   <= 4'h0;
      bit_q   <= 6'h0;
      tx_q    <= 33'h0;
      en_q    <= 33'h0;
      is_rd_q <= 1'b0;
      mdc_q   <= 1'b0;
      mdo_q   <= 1'b1;
      mdoe_q  <= 1'b0;
      rx_q    <= 16'h0;
    end
    else
    begin
      div_q <= (state_q == SST_IDLE || tick) ? 4'h0 : div_q + 4'h1;
      case (state_q)
        SST_IDLE:
        begin
          if (start)
          begin
            state_q <= SST_RUN;
            bit_q   <= 6'h0;
            is_rd_q <= !reg_wdata[CMD_WRITE];
            // lead bit released, then start, op, address, register, TA, data
            tx_q    <= {1'b1, START_CODE, reg_wdata[CMD_WRITE] ? OP_WRITE : OP_READ,
                        reg_wdata[9:0], TA_WRITE, wdata_q};
            en_q    <= reg_wdata[CMD_WRITE] ? {1'b0, 32'hFFFFFFFF} : {1'b0, 14'h3FFF, 18'h0};
          end
        end
        SST_RUN:
        begin
          if (tick)
          begin
            mdc_q <= ~mdc_q;
            if (!mdc_q)
            begin
              if (is_rd_q && bit_q >= STA_DATA0)
              begin
                rx_q <= {rx_q[14:0], mdio_sync_q[1]};
              end
              if (bit_q == STA_LAST)
              begin
                state_q <= SST_TAIL;
              end
            end
            else
            begin
              // change data on the falling edge, valid around the next rise
              bit_q  <= bit_q + 6'h1;
              mdo_q  <= tx_q[31];
              mdoe_q <= en_q[31];
              tx_q   <= {tx_q[31:0], 1'b0};
              en_q   <= {en_q[31:0], 1'b0};
            end
          end
        end
        SST_TAIL:
        begin
          // clock parks low between frames
          if (tick)
          begin
            mdc_q   <= 1'b0;
            mdoe_q  <= 1'b0;
            mdo_q   <= 1'b1;
            state_q <= SST_IDLE;
          end
        end
        default:
        begin
          state_q <= SST_IDLE;
        end
      endcase
    end
  end

  assign link.mdc         = mdc_q;
  assign link.sta_mdio_o  = mdo_q;
  assign link.sta_mdio_oe = mdoe_q;

endmodule // smi_station

// ### inc/smi_if.sv
// two-wire management link between station and device
`timescale 1ns/1ps
interface smi_if;
  logic mdc;
  logic sta_mdio_o;
  logic sta_mdio_oe;
  logic dev_mdio_o;
  logic dev_mdio_oe;
  logic mdio;

  // pulled high when nobody drives
  assign mdio = (~sta_mdio_oe | sta_mdio_o) & (~dev_mdio_oe | dev_mdio_o);

  modport sta (output mdc, output sta_mdio_o, output sta_mdio_oe, input mdio);
  modport dev (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe);
endinterface

// ### inc/smi_pkg.sv
// shared constants, types and helpers for the management serial link
package smi_pkg;

  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam logic [1:0] OP_READ      = 2'b10;
  localparam logic [1:0] OP_WRITE     = 2'b01;
  localparam logic [1:0] START_CODE   = 2'b01;
  localparam logic [1:0] TA_WRITE     = 2'b10;
  localparam logic [4:0] HDR_LAST_BIT = 5'h0B;
  localparam logic [4:0] TA2_BIT      = 5'h0D;
  localparam logic [4:0] DATA_FIRST   = 5'h0E;
  localparam logic [4:0] FRAME_LAST   = 5'h1D;

  // ****************************************************************
  // device register map and fields
  // ****************************************************************
  localparam logic [4:0]  REG_CTRL    = 5'h0D;
  localparam logic [4:0]  REG_DATA    = 5'h0E;
  localparam int          FN_HI       = 15;
  localparam int          FN_LO       = 14;
  localparam int          SEL_HI      = 4;
  localparam logic [15:0] REG_RST     = 16'h0000;
  localparam logic [15:0] PTR_RST     = 16'h0000;
  localparam logic [4:0]  SPACE_GEN   = 5'h1F;
  localparam logic [4:0]  SPACE_PMA   = 5'h01;
  localparam logic [4:0]  SPACE_VND   = 5'h03;
  localparam logic [1:0]  STRAP_WAIT  = 2'h2;

  typedef enum logic [1:0] {
    FN_ADDR   = 2'b00,
    FN_DATA   = 2'b01,
    FN_INC_RW = 2'b10,
    FN_INC_WR = 2'b11
  } smi_fn_type;

  typedef enum logic [1:0] {
    DST_IDLE  = 2'b00,
    DST_FRAME = 2'b01
  } smi_dev_state_type;

  // ****************************************************************
  // station timing and command registers
  // ****************************************************************
  localparam int          CLK_HZ      = 250_000_000;
  localparam int          MDC_MAX_HZ  = 24_000_000;
  localparam int          MDC_HALF    = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
  localparam logic [3:0]  MDC_HALF_M1 = 4'(MDC_HALF - 1);
  localparam logic [5:0]  POR_IDLE    = 6'(4 * MDC_HALF);
  localparam logic [5:0]  STA_LAST    = 6'h20;
  localparam logic [5:0]  STA_DATA0   = 6'h11;
  localparam logic [3:0]  STA_CMD     = 4'h0;
  localparam logic [3:0]  STA_WDATA   = 4'h4;
  localparam logic [3:0]  STA_RDATA   = 4'h8;
  localparam logic [3:0]  STA_STATUS  = 4'hC;
  localparam int          CMD_WRITE   = 15;

  typedef enum logic [1:0] {
    SST_IDLE = 2'b00,
    SST_RUN  = 2'b01,
    SST_TAIL = 2'b10
  } smi_sta_state_type;

  function automatic logic smi_space_ok(input logic [4:0] sel);
    return (sel == SPACE_GEN) || (sel == SPACE_PMA) || (sel == SPACE_VND);
  endfunction

endpackage

// ### tb/smi_link_properties.sv
// concurrent checks on the management link between station and device
`timescale 1ns/1ps
module smi_link_properties (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic mdc,
  input wire logic sta_mdio_o,
  input wire logic sta_mdio_oe,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe
);
  // ****************************************************************
  // helper logic
  // ****************************************************************
  logic       mdc_q;
  logic [4:0] drive_rises_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn) mdc_q <= 1'b0;
    else mdc_q <= mdc;
  end

  // counts mdc rises seen while the device holds the line
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn) drive_rises_q <= 5'h00;
    else if (!dev_mdio_oe) drive_rises_q <= 5'h00;
    else if (mdc && !mdc_q) drive_rises_q <= drive_rises_q + 5'h01;
  end

  // ****************************************************************
  // link properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_mdc_high;
    $rose(mdc) |-> mdc [*6] ##1 !mdc;
  endproperty
  a_mdc_high: assert property (p_mdc_high) else $error("mdc high phase not six clocks");

  property p_sta_hold;
    $rose(mdc) |-> ##1 ($stable(sta_mdio_o) && $stable(sta_mdio_oe)) [*4];
  endproperty
  a_sta_hold: assert property (p_sta_hold) else $error("station data moved after mdc rise");

  property p_dev_hold;
    (mdc && dev_mdio_oe && $past(dev_mdio_oe)) |-> $stable(dev_mdio_o);
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("device data moved while mdc high");

  property p_ta2_zero;
    $rose(dev_mdio_oe) |-> !dev_mdio_o && !mdc;
  endproperty
  a_ta2_zero: assert property (p_ta2_zero) else $error("device drive did not open with zero");

  property p_ta1_free;
    $rose(dev_mdio_oe) |-> !$past(sta_mdio_oe, 8);
  endproperty
  a_ta1_free: assert property (p_ta1_free) else $error("first turnaround bit not released");

  property p_no_fight;
    !(sta_mdio_oe && dev_mdio_oe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive the line");

  property p_dev_bits;
    $fell(dev_mdio_oe) |-> drive_rises_q == 5'h11;
  endproperty
  a_dev_bits: assert property (p_dev_bits) else $error("device drove wrong number of bits");

  property p_start;
    $rose(sta_mdio_oe) |-> !sta_mdio_o ##12 sta_mdio_o;
  endproperty
  a_start: assert property (p_start) else $error("frame did not open with start pattern");
endmodule // smi_link_properties

// ### tb/tb_smi_mmd_indirect_access.sv
// self-checking bench: station and device joined over the management link
`timescale 1ns/1ps
module tb_smi_mmd_indirect_access;
  import smi_pkg::*;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  localparam logic [4:0] OWN_ADDR = 5'h05;
  logic        clk_sys;
  logic        rstn;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [3:0]  bus_address_straps;
  logic        ext_rd;
  logic        ext_wr;
  logic [4:0]  ext_space;
  logic [15:0] ext_addr;
  logic [15:0] ext_wdata;
  logic [15:0] ext_rdata;
  logic [3:0]  bus_addr;
  logic [15:0] mem [256];
  logic [4:0]  last_space;
  int          failures;
  int          num_checks;
  int          ext_wr_cnt;

  smi_if link_if ();
  smi_station smi_station_inst (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link_if));
  smi_device smi_device_inst (.clk_sys(clk_sys), .rstn(rstn), .bus_address_straps(bus_address_straps),
    .link(link_if), .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_space(ext_space), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .bus_addr(bus_addr));
  smi_link_properties smi_link_properties_inst (.clk_sys(clk_sys), .rstn(rstn), .mdc(link_if.mdc),
    .sta_mdio_o(link_if.sta_mdio_o), .sta_mdio_oe(link_if.sta_mdio_oe), .dev_mdio_o(link_if.dev_mdio_o),
    .dev_mdio_oe(link_if.dev_mdio_oe));

  always #2 clk_sys = ~clk_sys;

  // extended space model; unread data inverts every cycle, so a read captured one cycle late sees the complement
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 256; i++) mem[i] <= 16'hC000 | 16'(i);
      last_space <= 5'h00;
      ext_rdata <= 16'h0000;
    end
    else
    begin
      if (ext_wr)
      begin
        mem[ext_addr[7:0]] <= ext_wdata;
        ext_wr_cnt <= ext_wr_cnt + 1;
        last_space <= ext_space;
      end
      ext_rdata <= ext_rd ? mem[ext_addr[7:0]] : ~ext_rdata;
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic smi_frame(input logic wr, input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd,
                           output logic [15:0] rd);
    logic [15:0] st;
    int          n;
    st = 16'h0000;
    n = 0;
    bus_write(STA_WDATA, wd);
    bus_write(STA_CMD, {wr, 5'h00, phy, ra});
    while (st[1] !== 1'b1 && n < 2000)
    begin
      bus_read(STA_STATUS, st);
      n++;
    end
    if (st[1] !== 1'b1) failures++;
    bus_write(STA_STATUS, 16'h0002);
    bus_read(STA_RDATA, rd);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    #250000;
    failures++;
    wrap_up();
  end

  initial
  begin
    logic [15:0] d;
    logic [15:0] p;
    logic [15:0] p1;
    logic [15:0] p2;
    logic [4:0]  sp;
    int          wcnt;
    clk_sys = 1'b0;
    rstn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bus_address_straps = 4'h5;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (30) @(posedge clk_sys);
    check("bus_addr", {12'h000, bus_addr}, 16'h0005);
    for (int i = 0; i < 3; i++)
    begin
      sp = (i == 0) ? 5'h00 : (i == 1) ? 5'h02 : 5'h1F;
      smi_frame(1'b1, OWN_ADDR, sp, 16'hA500 | 16'(i), d);
      smi_frame(1'b0, OWN_ADDR, sp, 16'h0000, d);
      check("direct_reg", d, 16'hA500 | 16'(i));
    end
    smi_frame(1'b1, 5'h06, 5'h02, 16'h5A5A, d);
    smi_frame(1'b1, 5'h15, 5'h02, 16'h5A5A, d);
    smi_frame(1'b0, OWN_ADDR, 5'h02, 16'h0000, d);
    check("foreign_write", d, 16'hA501);
    smi_frame(1'b0, 5'h06, 5'h02, 16'h0000, d);
    check("released_line", d, 16'hFFFF);
    smi_frame(1'b1, OWN_ADDR, REG_CTRL, 16'h001F, d);
    smi_frame(1'b0, OWN_ADDR, REG_CTRL, 16'h0000, d);
    check("ctrl_reg", d, 16'h001F);
    smi_frame(1'b1, OWN_ADDR, REG_DATA, 16'h0040, d);
    smi_frame(1'b1, OWN_ADDR, REG_DATA, 16'h0042, d);
    repeat (2)
    begin
      smi_frame(1'b0, OWN_ADDR, REG_DATA, 16'h0000, d);
      check("pointer_read", d, 16'h0042);
    end
    for (int fn = 1; fn < 4; fn++)
    begin
      for (int s = 0; s < 3; s++)
      begin
        sp = (s == 0) ? SPACE_GEN : (s == 1) ? SPACE_PMA : SPACE_VND;
        p = 16'(fn * 32 + s * 8);
        smi_frame(1'b1, OWN_ADDR, REG_CTRL, {11'h000, sp}, d);
        smi_frame(1'b1, OWN_ADDR, REG_DATA, p, d);
        smi_frame(1'b1, OWN_ADDR, REG_CTRL, {2'(fn), 9'h000, sp}, d);
        wcnt = ext_wr_cnt;
        smi_frame(1'b1, OWN_ADDR, REG_DATA, 16'h3C00 | p, d);
        check("ext_wr_count", 16'(ext_wr_cnt - wcnt), 16'h0001);
        check("ext_space", {11'h000, last_space}, {11'h000, sp});
        check("ext_wdata", mem[p[7:0]], 16'h3C00 | p);
        p1 = p + ((fn >= 2) ? 16'h0001 : 16'h0000);
        smi_frame(1'b0, OWN_ADDR, REG_DATA, 16'h0000, d);
        check("ext_read", d, (p1 == p) ? (16'h3C00 | p) : (16'hC000 | p1));
        p2 = p1 + ((fn == 2) ? 16'h0001 : 16'h0000);
        smi_frame(1'b1, OWN_ADDR, REG_CTRL, {11'h000, sp}, d);
        smi_frame(1'b0, OWN_ADDR, REG_DATA, 16'h0000, d);
        check("post_pointer", d, p2);
      end
    end
    smi_frame(1'b1, OWN_ADDR, REG_CTRL, 16'h0005, d);
    smi_frame(1'b1, OWN_ADDR, REG_DATA, 16'h0077, d);
    wcnt = ext_wr_cnt;
    smi_frame(1'b1, OWN_ADDR, REG_CTRL, 16'h4005, d);
    smi_frame(1'b1, OWN_ADDR, REG_DATA, 16'h1234, d);
    check("ignored_write", 16'(ext_wr_cnt - wcnt), 16'h0000);
    smi_frame(1'b0, OWN_ADDR, REG_DATA, 16'h0000, d);
    check("ignored_read", d, 16'h0000);
    smi_frame(1'b1, OWN_ADDR, REG_CTRL, 16'h001F, d);
    smi_frame(1'b0, OWN_ADDR, REG_DATA, 16'h0000, d);
    check("kept_pointer", d, p2);
    // reset lands mid-frame; the link must come back clean
    bus_write(STA_WDATA, 16'hBEEF);
    bus_write(STA_CMD, {1'b1, 5'h00, OWN_ADDR, 5'h02});
    repeat (100) @(posedge clk_sys);
    rstn <= 1'b0;
    bus_address_straps <= 4'h6;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (30) @(posedge clk_sys);
    check("bus_addr_new", {12'h000, bus_addr}, 16'h0006);
    smi_frame(1'b0, 5'h06, 5'h02, 16'h0000, d);
    check("after_reset", d, 16'h0000);
    smi_frame(1'b0, OWN_ADDR, 5'h02, 16'h0000, d);
    check("old_address", d, 16'hFFFF);
    wrap_up();
  end
endmodule // tb_smi_mmd_indirect_access
